// ===== design/urem_pkg.sv
`default_nettype none
package urem_pkg;
	localparam int OVS = 16;
	localparam logic [3:0] SMP_EDGE_A = 4'h2; // samples 3,5,7 (one based)
	localparam logic [3:0] SMP_EDGE_B = 4'h4;
	localparam logic [3:0] SMP_EDGE_C = 4'h6;
	localparam logic [3:0] SMP_MAJ_A = 4'h7; // samples 8,9,10 (one based)
	localparam logic [3:0] SMP_MAJ_B = 4'h8;
	localparam logic [3:0] SMP_MAJ_C = 4'h9;
	localparam logic [3:0] SMP_LAST = 4'hF;
	localparam logic [4:0] PR_SEL0 = 5'h01;
	localparam logic [4:0] PR_SEL1 = 5'h03;
	localparam logic [4:0] PR_SEL2 = 5'h04;
	localparam logic [4:0] PR_SEL3 = 5'h0D;
	localparam logic [3:0] BITS_SHORT = 4'h8;
	localparam logic [3:0] BITS_LONG = 4'h9;
	localparam logic [7:0] IDLE_SHORT = 8'hA0; // 10 bit times of 16 ticks
	localparam logic [7:0] IDLE_LONG = 8'hB0; // 11 bit times
	localparam logic [8:0] RST_BUF = 9'h000;
	localparam int FIFO_W = 9;
	localparam int FIFO_D = 4;
	typedef enum logic [1:0] {
		RX_HUNT = 2'b01,
		RX_FRAME = 2'b10
	} urem_rx_e;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} urem_tx_e;
endpackage
`default_nettype wire

// ===== design/urem_stream_if.sv
`default_nettype none
interface urem_stream_if #(parameter int W = 9);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== design/urem_fifo.sv
`default_nettype none
module urem_fifo #(
	parameter int W = 9,
	parameter int D = 4
) (
	input wire logic core_clk_i, // clock
	input wire logic rst_n_i, // synchronous reset, low
	urem_stream_if.snk wr, // filling side
	urem_stream_if.src rd // draining side
);
	localparam int AW = $clog2(D);
	initial begin
		if (D < 2 || (1 << AW) != D) begin
			$error("urem_fifo depth must be a power of two >= 2");
		end
	end
	logic [W-1:0] mem_r [D];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic full;
	logic empty;
	assign empty = (wp_r == rp_r);
	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem_r[rp_r[AW-1:0]];
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wp_r <= '0;
		end else if (wr.valid && !full) begin
			wp_r <= wp_r + 1'b1;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (wr.valid && !full) begin
			mem_r[wp_r[AW-1:0]] <= wr.data;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rp_r <= '0;
		end else if (rd.ready && !empty) begin
			rp_r <= rp_r + 1'b1;
		end
	end
	AST_FIFO_BOUND: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (wp_r - rp_r) <= (AW+1)'(D))
	else $error("fifo occupancy beyond depth");
endmodule
`default_nettype wire

// ===== design/urem_core.sv
//
// Overview of operation
// - received break handled as framing error
// - idle frame sets flag, optional interrupt
// - overrun keeps buffer, sets flag, interrupts if receive interrupt enabled
// - status read then data read clears errors
// - majority of samples 8-10, noise if differ in start or data bits
// - noise flag rises with full, no interrupt
// - false start discarded, noise held pending
// - bad stop sets framing flag, data moved
// - baud is clock/16/prescaler/power of two
// - nonzero extended prescaler divides further
// - mute blocks receive status and interrupts
// - idle wakes mute without idle flag
// - address mark wakes mute, word received
// - four frame formats, one start, stop
// - even or odd parity over low bits
// - transmit parity replaces data MSB
// - parity failure sets flag, optional interrupt
// - sixteen samples per bit, start resyncs
// - start noise from edge and samples
// - full set when character reaches buffer
`default_nettype none
module urem_core (
	input wire logic core_clk_i, // clock
	input wire logic rst_n_i, // synchronous reset, low
	input wire logic rxd_i, // serial receive line
	output logic txd_o, // serial transmit line
	input wire logic rx_en_i, // receiver enable
	input wire logic tx_en_i, // transmitter enable
	input wire logic word_len_i, // 1: nine bit words
	input wire logic parity_en_i, // parity on
	input wire logic parity_sel_i, // 1: odd parity
	input wire logic [1:0] baud_prescaler_field_i, // prescaler select
	input wire logic [2:0] tx_rate_field_i, // tx power of two
	input wire logic [2:0] rx_rate_field_i, // rx power of two
	input wire logic [7:0] tx_ext_prescaler_i, // tx extra divide
	input wire logic [7:0] rx_ext_prescaler_i, // rx extra divide
	input wire logic rx_mute_set_i, // software sets mute
	input wire logic rx_mute_clr_i, // software clears mute
	input wire logic wake_select_i, // 1: address mark wake
	input wire logic rx_int_en_i, // receive interrupt enable
	input wire logic idle_line_int_en_i, // idle interrupt enable
	input wire logic parity_int_en_i, // parity interrupt enable
	input wire logic int_mask_i, // cpu interrupt mask
	input wire logic status_rd_i, // status register read pulse
	input wire logic data_rd_i, // data register read pulse
	input wire logic tx_valid_i, // transmit word offered
	input wire logic [8:0] tx_data_i, // transmit word
	output logic tx_ready_o, // transmit queue has room
	output logic [8:0] rx_data_o, // receive buffer
	output logic rx_data_full_o, // receive buffer full
	output logic overrun_flag_o, // overrun
	output logic noise_flag_o, // noise
	output logic framing_error_flag_o, // framing error
	output logic parity_error_flag_o, // parity error
	output logic idle_flag_o, // idle line seen
	output logic rx_mute_o, // receiver muted
	output logic irq_o // interrupt request
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	function automatic logic maj3(input logic a, input logic b,
		input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic [18:0] baud_div(input logic [1:0] p,
		input logic [2:0] r, input logic [7:0] e);
		logic [18:0] base;
		logic [4:0] pv;
		pv = urem_pkg::PR_SEL0;
		unique case (p)
			2'd0: pv = urem_pkg::PR_SEL0;
			2'd1: pv = urem_pkg::PR_SEL1;
			2'd2: pv = urem_pkg::PR_SEL2;
			2'd3: pv = urem_pkg::PR_SEL3;
		endcase
		base = {14'h0, pv} << r;
		if (e != 8'h00) begin
			base = base * {11'h0, e};
		end
		return base;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// oversampling ticks; index 0 receive, 1 transmit
	logic [1:0] tick;
	logic [18:0] div_lim [2];
	assign div_lim[0] = baud_div(baud_prescaler_field_i, rx_rate_field_i,
		rx_ext_prescaler_i) - 19'h1;
	assign div_lim[1] = baud_div(baud_prescaler_field_i, tx_rate_field_i,
		tx_ext_prescaler_i) - 19'h1;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_div
			logic [18:0] cnt_r;
			logic en;
			assign en = (g == 0) ? rx_en_i : tx_en_i;
			assign tick[g] = en && (cnt_r == div_lim[g]);
			// limitation: divider is only reloaded on enable, so the
			// rate must stay fixed while a direction is enabled
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i || !en || tick[g]) begin
					cnt_r <= '0;
				end else begin
					cnt_r <= cnt_r + 19'h1;
				end
			end
			AST_DIV_PERIOD: assert property (
				en |-> cnt_r <= div_lim[g])
			else $error("divider count ran past its limit");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// receiver sampling
	urem_pkg::urem_rx_e rx_st_r;
	logic [3:0] samp_r;
	logic [3:0] bit_r;
	logic [2:0] hist_r;
	logic s8_r;
	logic s9_r;
	logic fr_noise_r;
	logic pend_noise_r;
	logic [8:0] shift_r;
	logic bad_stop;
	logic [3:0] nbits;
	logic maj;
	logic at_maj;
	logic frame_done;
	logic false_start;
	logic smp_noise;
	assign nbits = word_len_i ? urem_pkg::BITS_LONG : urem_pkg::BITS_SHORT;
	assign at_maj = tick[0] && (rx_st_r == urem_pkg::RX_FRAME) &&
		(samp_r == urem_pkg::SMP_MAJ_C);
	assign maj = maj3(s8_r, s9_r, rxd_i);
	assign smp_noise = !(s8_r == s9_r && s9_r == rxd_i);
	assign false_start = at_maj && (bit_r == 4'h0) && maj;
	assign frame_done = at_maj && (bit_r == nbits + 4'h1);
	assign bad_stop = !maj;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !rx_en_i) begin
			rx_st_r <= urem_pkg::RX_HUNT;
		end else if (tick[0]) begin
			unique case (rx_st_r)
				urem_pkg::RX_HUNT: if (!rxd_i) begin
					rx_st_r <= urem_pkg::RX_FRAME;
				end
				urem_pkg::RX_FRAME: if (false_start || frame_done) begin
					rx_st_r <= urem_pkg::RX_HUNT;
				end
			endcase
		end
	end

	// sample counter restarts on the falling edge: resync per frame
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !rx_en_i) begin
			samp_r <= '0;
			bit_r <= '0;
		end else if (tick[0]) begin
			if (rx_st_r == urem_pkg::RX_HUNT) begin
				samp_r <= 4'h1;
				bit_r <= '0;
			end else begin
				samp_r <= samp_r + 4'h1;
				if (samp_r == urem_pkg::SMP_LAST) begin
					bit_r <= bit_r + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			hist_r <= 3'b000;
		end else if (tick[0] && rx_st_r == urem_pkg::RX_HUNT) begin
			hist_r <= {hist_r[1:0], rxd_i};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s8_r <= 1'b0;
			s9_r <= 1'b0;
		end else if (tick[0] && rx_st_r == urem_pkg::RX_FRAME) begin
			if (samp_r == urem_pkg::SMP_MAJ_A) begin
				s8_r <= rxd_i;
			end
			if (samp_r == urem_pkg::SMP_MAJ_B) begin
				s9_r <= rxd_i;
			end
		end
	end

	// noise gathered through the frame; start bit noise also covers edge
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fr_noise_r <= 1'b0;
		end else if (tick[0]) begin
			if (rx_st_r == urem_pkg::RX_HUNT) begin
				fr_noise_r <= (hist_r != 3'b111);
			end else if (bit_r == 4'h0 && rxd_i &&
				(samp_r == urem_pkg::SMP_EDGE_A ||
				samp_r == urem_pkg::SMP_EDGE_B ||
				samp_r == urem_pkg::SMP_EDGE_C ||
				samp_r == urem_pkg::SMP_MAJ_A ||
				samp_r == urem_pkg::SMP_MAJ_B)) begin
				fr_noise_r <= 1'b1;
			end else if (at_maj && smp_noise) begin
				fr_noise_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (at_maj && bit_r != 4'h0 && bit_r <= nbits) begin
			shift_r <= {maj, shift_r[8:1]}; // lsb first
		end
	end

	////////////////////////////////////////////////////////////////////////
	// word assembly, parity, idle detection
	logic [8:0] word;
	logic msb;
	logic par_bad;
	logic wake_addr;
	logic deliver;
	logic [7:0] idle_cnt_r;
	logic idle_arm_r;
	logic idle_evt;
	logic seq_clr;
	logic status_seen_r;
	assign word = word_len_i ? shift_r : {1'b0, shift_r[8:1]};
	// with parity on, the top data bit sits just below the parity bit
	assign msb = parity_en_i ? (word_len_i ? word[7] : word[6]) :
		(word_len_i ? word[8] : word[7]);
	assign par_bad = parity_en_i && ((word_len_i ? ^word[8:0] :
		^word[7:0]) != parity_sel_i);
	assign wake_addr = frame_done && rx_mute_o && wake_select_i && msb;
	assign deliver = frame_done && (!rx_mute_o || wake_addr);
	assign idle_evt = idle_arm_r && tick[0] &&
		rx_st_r == urem_pkg::RX_HUNT && rxd_i &&
		idle_cnt_r == (word_len_i ? urem_pkg::IDLE_LONG :
		urem_pkg::IDLE_SHORT) - 8'h1;
	assign seq_clr = data_rd_i && status_seen_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !rx_en_i || !rxd_i || frame_done || idle_evt) begin
			idle_cnt_r <= '0;
		end else if (tick[0] && rx_st_r == urem_pkg::RX_HUNT) begin
			idle_cnt_r <= idle_cnt_r + 8'h1;
		end
	end

	// one idle event per quiet period; re-armed by each frame or enable
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !rx_en_i || frame_done) begin
			idle_arm_r <= 1'b1;
		end else if (idle_evt) begin
			idle_arm_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || data_rd_i) begin
			status_seen_r <= 1'b0;
		end else if (status_rd_i) begin
			status_seen_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags; a new event wins over a clearing read
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_mute_o <= 1'b0;
		end else if (rx_mute_set_i) begin
			rx_mute_o <= 1'b1;
		end else if (rx_mute_clr_i || wake_addr) begin
			rx_mute_o <= 1'b0;
		end else if (idle_evt && !wake_select_i) begin
			rx_mute_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pend_noise_r <= 1'b0;
		end else if (false_start) begin
			pend_noise_r <= 1'b1;
		end else if (deliver && !rx_data_full_o) begin
			pend_noise_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_data_o <= urem_pkg::RST_BUF;
		end else if (deliver && !rx_data_full_o) begin
			rx_data_o <= word;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_data_full_o <= 1'b0;
			noise_flag_o <= 1'b0;
			framing_error_flag_o <= 1'b0;
			parity_error_flag_o <= 1'b0;
		end else if (deliver && !rx_data_full_o) begin
			rx_data_full_o <= 1'b1;
			noise_flag_o <= fr_noise_r || pend_noise_r;
			framing_error_flag_o <= bad_stop;
			parity_error_flag_o <= par_bad;
		end else if (seq_clr) begin
			rx_data_full_o <= 1'b0;
			noise_flag_o <= 1'b0;
			framing_error_flag_o <= 1'b0;
			parity_error_flag_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			overrun_flag_o <= 1'b0;
		end else if (deliver && rx_data_full_o) begin
			overrun_flag_o <= 1'b1;
		end else if (seq_clr) begin
			overrun_flag_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			idle_flag_o <= 1'b0;
		end else if (idle_evt && !rx_mute_o) begin
			idle_flag_o <= 1'b1;
		end else if (seq_clr) begin
			idle_flag_o <= 1'b0;
		end
	end

	// noise and framing flags have no enable of their own
	assign irq_o = !int_mask_i && !rx_mute_o && (
		(rx_int_en_i && (rx_data_full_o || overrun_flag_o)) ||
		(idle_line_int_en_i && idle_flag_o) ||
		(parity_int_en_i && parity_error_flag_o));

	////////////////////////////////////////////////////////////////////////
	// transmitter behind the queue
	urem_stream_if #(.W(urem_pkg::FIFO_W)) wr_if();
	urem_stream_if #(.W(urem_pkg::FIFO_W)) rd_if();
	assign wr_if.valid = tx_valid_i;
	assign wr_if.data = tx_data_i;
	assign tx_ready_o = wr_if.ready;
	urem_fifo #(.W(urem_pkg::FIFO_W), .D(urem_pkg::FIFO_D)) u_txq (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.wr(wr_if),
		.rd(rd_if)
	);

	urem_pkg::urem_tx_e tx_st_r;
	logic [10:0] tx_sh_r;
	logic [3:0] tx_left_r;
	logic [3:0] tx_smp_r;
	logic [8:0] tx_word;
	logic tx_par;
	logic tx_take;
	assign tx_par = (word_len_i ? ^rd_if.data[7:0] : ^rd_if.data[6:0]) ^
		parity_sel_i;
	always_comb begin
		tx_word = rd_if.data;
		if (parity_en_i && word_len_i) begin
			tx_word[8] = tx_par;
		end else if (parity_en_i) begin
			tx_word[7] = tx_par;
		end
	end
	assign tx_take = tx_en_i && tx_st_r == urem_pkg::TX_IDLE &&
		rd_if.valid;
	assign rd_if.ready = tx_take;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !tx_en_i) begin
			tx_st_r <= urem_pkg::TX_IDLE;
			tx_sh_r <= '1;
			tx_left_r <= '0;
			tx_smp_r <= '0;
		end else if (tx_take) begin
			tx_st_r <= urem_pkg::TX_SEND;
			tx_sh_r <= word_len_i ? {1'b1, tx_word, 1'b0} :
				{2'b11, tx_word[7:0], 1'b0};
			tx_left_r <= nbits + 4'h2;
			tx_smp_r <= '0;
		end else if (tick[1] && tx_st_r == urem_pkg::TX_SEND) begin
			tx_smp_r <= tx_smp_r + 4'h1;
			if (tx_smp_r == urem_pkg::SMP_LAST) begin
				tx_sh_r <= {1'b1, tx_sh_r[10:1]};
				tx_left_r <= tx_left_r - 4'h1;
				if (tx_left_r == 4'h1) begin
					tx_st_r <= urem_pkg::TX_IDLE;
				end
			end
		end
	end
	assign txd_o = tx_sh_r[0];

	////////////////////////////////////////////////////////////////////////
	AST_OVR_KEEP: assert property (
		deliver && rx_data_full_o |=> overrun_flag_o &&
		rx_data_o == $past(rx_data_o))
	else $error("overrun did not hold buffer and set flag");
	AST_MUTE_QUIET: assert property (
		$rose(rx_data_full_o) |-> !$past(rx_mute_o) || $past(wake_addr))
	else $error("status set while muted");
	AST_CLR_SEQ: assert property (
		$fell(noise_flag_o) || $fell(framing_error_flag_o) ||
		$fell(overrun_flag_o) |-> $past(data_rd_i) && $past(status_seen_r))
	else $error("error flag cleared without read sequence");
	AST_NOISE_WITH_FULL: assert property (
		$rose(noise_flag_o) |-> $rose(rx_data_full_o))
	else $error("noise flag rose apart from full");
	AST_FE_WITH_FULL: assert property (
		$rose(framing_error_flag_o) |-> $rose(rx_data_full_o))
	else $error("framing flag rose apart from full");
	AST_FALSE_DISCARD: assert property (
		false_start |=> pend_noise_r && rx_st_r == urem_pkg::RX_HUNT &&
		!$rose(rx_data_full_o))
	else $error("false start not discarded");
	AST_IDLE_WAKE: assert property (
		idle_evt && rx_mute_o && !wake_select_i && !rx_mute_set_i |=>
		!rx_mute_o && !$rose(idle_flag_o))
	else $error("idle wake-up wrong");
	AST_ADDR_WAKE: assert property (
		wake_addr && !rx_mute_set_i && !rx_data_full_o |=>
		!rx_mute_o && rx_data_full_o)
	else $error("address mark wake-up wrong");
	AST_TX_PARITY: assert property (
		tx_take && parity_en_i |=> (word_len_i ? ^tx_sh_r[9:1] :
		^tx_sh_r[8:1]) == parity_sel_i)
	else $error("transmit parity wrong");
endmodule
`default_nettype wire

// ===== bench/urem_remote_tx.sv
`default_nettype none
module urem_remote_tx (
	input wire logic core_clk_i, // clock
	input wire logic rst_n_i, // synchronous reset, low
	input wire logic go_i, // start one frame
	input wire logic [11:0] bits_i, // line levels, first bit in 0
	input wire logic [3:0] len_i, // number of bits to send
	input wire logic [11:0] bt_i, // clocks per bit
	input wire logic [3:0] glitch_i, // bit to disturb, 4'hF for none
	output logic busy_o, // frame on the line
	output logic rxd_o // serial line towards the receiver
);
	logic [3:0] idx_r;
	logic [11:0] cnt_r;
	logic flip;
	////////////////////////////////////////////////////////////////////////
	// one clock inverted mid-bit: only the middle sample disagrees
	assign flip = (idx_r == glitch_i) && (cnt_r == (bt_i >> 1));
	// a released line idles high, as a marking line does
	assign rxd_o = busy_o ? (bits_i[idx_r] ^ flip) : 1'h1;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'h0;
			idx_r <= 4'h0;
			cnt_r <= 12'h000;
		end else if (!busy_o) begin
			if (go_i) begin
				busy_o <= 1'h1;
				idx_r <= 4'h0;
				cnt_r <= 12'h000;
			end
		end else if (cnt_r == bt_i - 12'h001) begin
			cnt_r <= 12'h000;
			if (idx_r == len_i - 4'h1) begin
				busy_o <= 1'h0;
			end else begin
				idx_r <= idx_r + 4'h1;
			end
		end else begin
			cnt_r <= cnt_r + 12'h001;
		end
	end
endmodule
`default_nettype wire

// ===== bench/urem_core_bench.sv
`default_nettype none
module urem_core_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic wl;
		logic pen;
		logic ps;
		logic [8:0] w;
		logic pe;
	} urem_row_s;
	logic clk, rst_n, rxd, rx_en, wl, pen, psel, mset, wsel;
	logic rx_int_en, idle_line_int_en, parity_int_en, mask, srd, drd, go, busy, txd, tx_rdy, ten, tval;
	logic full, ovr, nf, fe, pe, idle, mute, irq;
	logic [1:0] pr;
	logic [2:0] rr;
	logic [7:0] ext;
	logic [11:0] bt, bits;
	logic [8:0] rdata, tdat;
	logic [3:0] len, gl;
	int n_mismatch = 0;
	int compares = 0;
	urem_row_s rows [7] = '{'{1'h0, 1'h0, 1'h0, 9'h0A5, 1'h0},
		'{1'h0, 1'h1, 1'h0, 9'h035, 1'h0}, '{1'h0, 1'h1, 1'h0, 9'h0B5, 1'h1},
		'{1'h0, 1'h1, 1'h1, 9'h0B5, 1'h0}, '{1'h1, 1'h0, 1'h0, 9'h1C3, 1'h0},
		'{1'h1, 1'h1, 1'h0, 9'h1FF, 1'h1}, '{1'h1, 1'h1, 1'h1, 9'h1FF, 1'h0}};
	// prescaler, power of two, extra divide, clocks per bit
	logic [24:0] bauds [5] = '{{2'h0, 3'h0, 8'h00, 12'h010},
		{2'h1, 3'h1, 8'h00, 12'h060}, {2'h3, 3'h0, 8'h00, 12'h0D0},
		{2'h0, 3'h0, 8'h02, 12'h020}, {2'h2, 3'h2, 8'h03, 12'h300}};
	////////////////////////////////////////////////////////////////////////
	urem_core urem_core_i (.core_clk_i(clk), .rst_n_i(rst_n), .rxd_i(rxd),
		.txd_o(txd), .rx_en_i(rx_en), .tx_en_i(ten), .word_len_i(wl),
		.parity_en_i(pen), .parity_sel_i(psel), .baud_prescaler_field_i(pr),
		.tx_rate_field_i(3'h0), .rx_rate_field_i(rr),
		.tx_ext_prescaler_i(8'h00), .rx_ext_prescaler_i(ext),
		.rx_mute_set_i(mset), .rx_mute_clr_i(1'h0), .wake_select_i(wsel),
		.rx_int_en_i(rx_int_en), .idle_line_int_en_i(idle_line_int_en), .parity_int_en_i(parity_int_en),
		.int_mask_i(mask), .status_rd_i(srd), .data_rd_i(drd),
		.tx_valid_i(tval), .tx_data_i(tdat), .tx_ready_o(tx_rdy),
		.rx_data_o(rdata), .rx_data_full_o(full), .overrun_flag_o(ovr),
		.noise_flag_o(nf), .framing_error_flag_o(fe),
		.parity_error_flag_o(pe), .idle_flag_o(idle), .rx_mute_o(mute),
		.irq_o(irq));
	urem_remote_tx urem_remote_tx_i (.core_clk_i(clk), .rst_n_i(rst_n),
		.go_i(go), .bits_i(bits), .len_i(len), .bt_i(bt), .glitch_i(gl),
		.busy_o(busy), .rxd_o(rxd));
	////////////////////////////////////////////////////////////////////////
	task chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			n_mismatch++;
		end
	endtask
	task stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// start bit, nb data bits LSB first, stop level stp
	task frame(input logic [8:0] w, input int nb, input logic stp,
			input logic [3:0] g);
		int n;
		@(posedge clk);
		bits <= (12'(w & 9'((1 << nb) - 1)) << 1) | (12'(stp) << (nb + 1));
		len <= 4'(nb + 2);
		gl <= g;
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		#1;
		n = 0;
		while (busy !== 1'h0 && n < 9000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	// status read, then data read, then one edge for the flags to drop
	task clr;
		@(posedge clk);
		srd <= 1'h1;
		@(posedge clk);
		srd <= 1'h0;
		drd <= 1'h1;
		@(posedge clk);
		drd <= 1'h0;
		@(posedge clk);
		#1;
	endtask
	task gap(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		gap(60000);
		n_mismatch++;
		stop_test;
	end
	initial begin
		{rst_n, rx_en, wl, pen, psel, mset, wsel, rx_int_en, idle_line_int_en} = '0;
		{parity_int_en, mask, srd, drd, go, pr, rr, ext, bits, len} = '0;
		{ten, tval, tdat} = '0;
		bt = 12'h010;
		gl = 4'hF;
		gap(6);
		rst_n <= 1'h1;
		gap(1);
		chk("reset", {txd, tx_rdy, full, ovr, nf, fe, pe, idle, irq}, 9'h180);
		chk("reset_mute", mute, 9'h000);
		$display("test reset done");
		rx_en <= 1'h1;
		parity_int_en <= 1'h1;
		gap(40);
		foreach (rows[i]) begin
			@(posedge clk);
			{wl, pen, psel} <= {rows[i].wl, rows[i].pen, rows[i].ps};
			frame(rows[i].w, rows[i].wl ? 9 : 8, 1'h1, 4'hF);
			chk("full", full, 9'h001);
			chk("data", rdata, rows[i].w);
			chk("parity", pe, 9'(rows[i].pe));
			chk("irq_parity", irq, 9'(rows[i].pe));
			clr;
			chk("cleared", {full, pe}, 9'h000);
			$display("test row %0d done", i);
		end
		{wl, pen} <= 2'h0;
		frame(9'h05A, 8, 1'h1, 4'h3);
		chk("noisy_data", rdata, 9'h05A);
		chk("noise_with_full", {nf, full, irq}, 9'h006);
		clr;
		$display("test noise done");
		bt <= 12'h008;
		frame(9'h000, 0, 1'h1, 4'hF);
		gap(40);
		chk("false_start", full, 9'h000);
		bt <= 12'h010;
		frame(9'h033, 8, 1'h1, 4'hF);
		chk("pending_noise", {nf, full}, 9'h003);
		chk("after_false", rdata, 9'h033);
		clr;
		$display("test false start done");
		rx_int_en <= 1'h1;
		frame(9'h011, 8, 1'h1, 4'hF);
		chk("irq_full", irq, 9'h001);
		frame(9'h022, 8, 1'h1, 4'hF);
		chk("overrun", {ovr, irq}, 9'h003);
		chk("kept", rdata, 9'h011);
		@(posedge clk);
		drd <= 1'h1;
		@(posedge clk);
		drd <= 1'h0;
		gap(2);
		chk("no_status_read", ovr, 9'h001);
		clr;
		chk("ovr_cleared", {ovr, full}, 9'h000);
		rx_int_en <= 1'h0;
		$display("test overrun done");
		@(posedge clk);
		wsel <= 1'h1;
		mset <= 1'h1;
		@(posedge clk);
		mset <= 1'h0;
		frame(9'h012, 8, 1'h1, 4'h3);
		chk("muted", {full, nf, mute}, 9'h001);
		frame(9'h092, 8, 1'h1, 4'hF);
		chk("address_wake", {mute, full}, 9'h001);
		chk("address", rdata, 9'h092);
		clr;
		wsel <= 1'h0;
		mset <= 1'h1;
		@(posedge clk);
		mset <= 1'h0;
		frame(9'h044, 8, 1'h1, 4'hF);
		chk("muted_idle", full, 9'h000);
		gap(200);
		chk("idle_wake", {mute, idle}, 9'h000);
		$display("test mute done");
		idle_line_int_en <= 1'h1;
		frame(9'h055, 8, 1'h1, 4'hF);
		clr;
		gap(200);
		chk("idle", {idle, full, irq}, 9'h005);
		mask <= 1'h1;
		gap(1);
		chk("masked", irq, 9'h000);
		clr;
		{idle_line_int_en, mask} <= 2'h0;
		$display("test idle done");
		// four words fill the queue while the transmitter is held off
		{wl, pen, psel} <= 3'b010;
		tdat <= 9'h0B5;
		tval <= 1'h1;
		gap(4);
		tval <= 1'h0;
		chk("tx_queue_full", tx_rdy, 9'h000);
		ten <= 1'h1;
		gap(1);
		chk("tx_start", {txd, tx_rdy}, 9'h001);
		gap(128);
		chk("tx_parity", txd, 9'h000);
		gap(16);
		chk("tx_stop", txd, 9'h001);
		{ten, pen} <= 2'h0;
		$display("test transmit done");
		foreach (bauds[i]) begin
			@(posedge clk);
			rx_en <= 1'h0;
			@(posedge clk);
			{pr, rr, ext, bt} <= bauds[i];
			@(posedge clk);
			rx_en <= 1'h1;
			gap(int'(bauds[i][11:0]));
			frame(9'h0C0 | 9'(i), 8, 1'h1, 4'hF);
			chk("baud_full", full, 9'h001);
			chk("baud_data", rdata, 9'h0C0 | 9'(i));
			clr;
			$display("test baud %0d done", i);
		end
		frame(9'h000, 8, 1'h0, 4'hF);
		chk("break", {fe, full}, 9'h003);
		chk("break_data", rdata, 9'h000);
		clr;
		chk("fe_cleared", fe, 9'h000);
		$display("test break done");
		stop_test;
	end
endmodule
`default_nettype wire
